/* logic/cpld_pkg.sv */
// shared constants, carriers and arithmetic for the charge pump control
package cpld_pkg;

    // ------------------------------------------------------------------
    // field widths
    // ------------------------------------------------------------------
    localparam int GAIN_W  = 8;   // pump gain code
    localparam int SHIFT_W = 2;   // speed-up shift code
    localparam int RATIO_W = 4;   // integral ratio code
    localparam int FRAC_W  = 3;   // fraction residue
    localparam int MOD_W   = 4;   // accumulator modulus and sum
    localparam int MAG_W   = 16;  // current magnitude codes
    localparam int EDGE_W  = 2;   // slip edge counter

    // ------------------------------------------------------------------
    // values
    // ------------------------------------------------------------------
    // accumulator modulus when the select bit is one
    localparam logic [MOD_W-1:0]   FRAC_MOD_SEL1  = 4'h8;
    // accumulator modulus when the select bit is zero (plain default)
    localparam logic [MOD_W-1:0]   FRAC_MOD_SEL0  = 4'h5;
    // error pulse spanning this many reference edges is a full cycle
    localparam logic [EDGE_W-1:0]  SLIP_EDGES     = 2'h2;
    localparam logic [EDGE_W-1:0]  EDGE_ONE       = 2'h1;
    localparam logic [MAG_W-1:0]   MAG_ONE        = 16'h0001;
    localparam logic [MAG_W-1:0]   MAG_ZERO       = 16'h0000;
    localparam logic [SHIFT_W:0]   SHIFT_BIAS     = 3'h1;
    localparam logic [FRAC_W-1:0]  FRAC_RESET     = 3'h0;

    // ------------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [GAIN_W-1:0]  pump_gain_code;
        logic [SHIFT_W-1:0] speedup_shift_code;
        logic [RATIO_W-1:0] integral_ratio_code;
    } cpld_aword_t;

    localparam cpld_aword_t AWORD_RESET = '0;

    // one pump output: direction, pump magnitude in units of
    // main_current_ref/29, compensation magnitude in units of
    // compensation_current_ref/128 (compensation always pulls down)
    typedef struct packed {
        logic             up;
        logic             down;
        logic [MAG_W-1:0] pump_mag;
        logic             comp_on;
        logic [MAG_W-1:0] comp_mag;
    } cpld_drive_t;

    localparam cpld_drive_t DRIVE_RESET = '0;

    typedef enum logic [1:0] {
        CMP_IDLE,
        CMP_BEFORE,
        CMP_PULSE,
        CMP_AFTER
    } cpld_comp_state_t;

    // ------------------------------------------------------------------
    // arithmetic
    // ------------------------------------------------------------------
    // two raised to (shift code plus one)
    function automatic logic [MAG_W-1:0] speedup_factor(
        input logic [SHIFT_W-1:0] shift);
        logic [SHIFT_W:0] amount;
        amount = {1'b0, shift} + SHIFT_BIAS;
        return MAG_ONE << amount;
    endfunction

    // magnitude times a multiplier, kept to the magnitude width
    function automatic logic [MAG_W-1:0] scale(
        input logic [MAG_W-1:0] mag,
        input logic [MAG_W-1:0] mult);
        logic [2*MAG_W-1:0] prod;
        prod = mag * mult;
        return prod[MAG_W-1:0];
    endfunction

endpackage

/* logic/cpld_lock_mon.sv */
// lock monitor for one phase detector
`timescale 1ns/1ps

module cpld_lock_mon
    import cpld_pkg::*;
(
    input  wire logic i_sys_clk,
    input  wire logic i_reset,
    input  wire logic i_ref_tick,
    input  wire logic i_enable,
    input  wire logic i_up,
    input  wire logic i_down,
    output logic      o_locked
);

    // ------------------------------------------------------------------
    // error pulse measurement
    // ------------------------------------------------------------------
    logic              err_prev;
    logic [EDGE_W-1:0] edge_cnt;
    wire               err      = i_up | i_down;
    wire               err_end  = err_prev & ~err;
    wire               slipped  = (edge_cnt >= SLIP_EDGES);
    wire               count_up = err & i_ref_tick & ~slipped;

    // two reference edges inside one error pulse means the phase
    // difference reached a whole reference cycle
    always_ff @(posedge i_sys_clk)
    begin
        if (i_reset)
        begin
            err_prev <= 1'b0;
            edge_cnt <= '0;
            o_locked <= 1'b0;
        end
        else if (!i_enable)
        begin
            err_prev <= 1'b0;
            edge_cnt <= '0;
            o_locked <= 1'b1;
        end
        else
        begin
            err_prev <= err;
            if (count_up)
                edge_cnt <= edge_cnt + EDGE_ONE;
            else if (!err)
                edge_cnt <= '0;
            if (slipped)
                o_locked <= 1'b0;
            else if (err_end)
                o_locked <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    a_disabled_locked: assert property (@(posedge i_sys_clk)
        disable iff (i_reset) !i_enable |=> o_locked)
        else $error("disabled detector not reported locked");

    a_slip_unlocks: assert property (@(posedge i_sys_clk)
        disable iff (i_reset)
        (i_enable && slipped) ##1 i_enable |-> !o_locked)
        else $error("full cycle slip did not drop lock");

endmodule // cpld_lock_mon

/* logic/cpld_top.sv */
// charge pump mode, current codes, compensation timing and lock detect
`timescale 1ns/1ps
// How it works
// - compensation on one reference cycle before and after divider pulse
// - after A word load, speed-up while strobe high, else normal mode
// - normal mode: integral output zero; proportional is pump plus comp
// - normal pump magnitude is gain code in units of reference/29
// - normal comp magnitude is residue in units of comp reference/128
// - speed-up adds pump and comp, each times two to (shift+1)
// - speed-up integral carries extra pump and comp times ratio code
// - lock output high only when main and auxiliary detectors lock
// - detector locks when phase error stays under one reference cycle
// - a disabled detector counts as locked
// - fraction accumulator counts modulo Q, Q is 8 with select one

module cpld_top
    import cpld_pkg::*;
(
    input  wire logic        i_sys_clk,
    input  wire logic        i_reset,
    input  wire logic        i_reference_input,
    input  wire logic        i_ref_pulse_due,
    input  wire logic        i_main_div_pulse,
    input  wire logic [2:0]  i_frac_step,
    input  wire logic        i_fraction_modulus_select,
    input  wire logic        i_main_enable_bit,
    input  wire logic        i_aux_enable_bit,
    input  wire logic        i_aword_load,
    input  wire cpld_aword_t i_aword,
    input  wire logic        i_strobe,
    input  wire logic        i_main_up,
    input  wire logic        i_main_down,
    input  wire logic        i_aux_up,
    input  wire logic        i_aux_down,
    output cpld_drive_t      o_proportional_pump_out,
    output cpld_drive_t      o_integral_pump_out,
    output logic             o_speedup,
    output logic             o_comp_window,
    output logic [2:0]       o_fraction_residue,
    output logic             o_frac_overflow,
    output logic             o_lock
);

    // ------------------------------------------------------------------
    // reference input edge
    // ------------------------------------------------------------------
    logic ref_prev;
    wire  ref_tick = i_reference_input & ~ref_prev;

    // one edge per reference cycle; the input is already synchronous.
    // the pin is followed in reset too, so a reference that is high at
    // release is not taken for a fresh edge
    always_ff @(posedge i_sys_clk)
    begin
        ref_prev <= i_reference_input;
    end

    // ------------------------------------------------------------------
    // compensation window
    // ------------------------------------------------------------------
    cpld_comp_state_t comp_state;
    cpld_comp_state_t next_comp_state;
    wire              comp_active = (comp_state != CMP_IDLE);

    // the reference divider announces its pulse one cycle early, so the
    // window opens ahead of the pulse without any look-ahead of our own
    always_comb
    begin
        next_comp_state = comp_state;
        if (ref_tick)
        begin
            unique case (comp_state)
                CMP_IDLE:   next_comp_state = i_ref_pulse_due ?
                                CMP_BEFORE : CMP_IDLE;
                CMP_BEFORE: next_comp_state = CMP_PULSE;
                CMP_PULSE:  next_comp_state = CMP_AFTER;
                CMP_AFTER:  next_comp_state = i_ref_pulse_due ?
                                CMP_BEFORE : CMP_IDLE;
            endcase
        end
    end

    always_ff @(posedge i_sys_clk)
    begin
        if (i_reset)
            comp_state <= CMP_IDLE;
        else
            comp_state <= next_comp_state;
    end

    // ------------------------------------------------------------------
    // fractional accumulator
    // ------------------------------------------------------------------
    logic [FRAC_W-1:0] frac_acc;
    wire  [MOD_W-1:0]  frac_mod = i_fraction_modulus_select ?
                                  FRAC_MOD_SEL1 : FRAC_MOD_SEL0;
    wire  [MOD_W-1:0]  frac_sum = {1'b0, frac_acc} + {1'b0, i_frac_step};
    wire               frac_wrap = (frac_sum >= frac_mod);
    wire  [MOD_W-1:0]  frac_left = frac_sum - frac_mod;
    wire  [FRAC_W-1:0] next_frac_acc = frac_wrap ?
                                  frac_left[FRAC_W-1:0] :
                                  frac_sum[FRAC_W-1:0];

    // the step must stay below the modulus; a larger step wraps once only
    always_ff @(posedge i_sys_clk)
    begin
        if (i_reset)
        begin
            frac_acc        <= FRAC_RESET;
            o_frac_overflow <= 1'b0;
        end
        else
        begin
            o_frac_overflow <= i_main_div_pulse & frac_wrap;
            if (i_main_div_pulse)
                frac_acc <= next_frac_acc;
        end
    end

    assign o_fraction_residue = frac_acc;

    // ------------------------------------------------------------------
    // A word codes and mode
    // ------------------------------------------------------------------
    cpld_aword_t codes;
    logic        armed;
    wire         speedup = armed & i_strobe;

    // codes change only with a load, so a mode switch never glitches
    // the current settings mid cycle
    always_ff @(posedge i_sys_clk)
    begin
        if (i_reset)
        begin
            codes <= AWORD_RESET;
            armed <= 1'b0;
        end
        else if (i_aword_load)
        begin
            codes <= i_aword;
            armed <= 1'b1;
        end
        else if (!i_strobe)
            armed <= 1'b0;
    end

    // ------------------------------------------------------------------
    // current codes
    // ------------------------------------------------------------------
    wire [MAG_W-1:0] factor   = speedup_factor(codes.speedup_shift_code);
    wire [MAG_W-1:0] ratio    = {{(MAG_W-RATIO_W){1'b0}},
                                 codes.integral_ratio_code};
    wire [MAG_W-1:0] pump_n   = {{(MAG_W-GAIN_W){1'b0}},
                                 codes.pump_gain_code};
    wire [MAG_W-1:0] frd_gate = comp_active ?
                                {{(MAG_W-FRAC_W){1'b0}}, frac_acc} :
                                MAG_ZERO;
    wire [MAG_W-1:0] comp_n   = frd_gate;
    wire [MAG_W-1:0] pump_x   = scale(pump_n, factor);
    wire [MAG_W-1:0] comp_x   = scale(comp_n, factor);
    wire [MAG_W-1:0] prop_pump = speedup ? pump_n + pump_x : pump_n;
    wire [MAG_W-1:0] prop_comp = speedup ? comp_n + comp_x : comp_n;
    wire [MAG_W-1:0] int_pump = speedup ?
                                scale(pump_x, ratio) : MAG_ZERO;
    wire [MAG_W-1:0] int_comp = speedup ?
                                scale(comp_x, ratio) : MAG_ZERO;

    cpld_drive_t next_prop;
    cpld_drive_t next_int;

    // proportional output is always live; integral only in speed-up
    always_comb
    begin
        next_prop.up       = i_main_up;
        next_prop.down     = i_main_down;
        next_prop.pump_mag = prop_pump;
        next_prop.comp_on  = comp_active;
        next_prop.comp_mag = prop_comp;
        next_int.up        = speedup & i_main_up;
        next_int.down      = speedup & i_main_down;
        next_int.pump_mag  = int_pump;
        next_int.comp_on   = speedup & comp_active;
        next_int.comp_mag  = int_comp;
    end

    always_ff @(posedge i_sys_clk)
    begin
        if (i_reset)
        begin
            o_proportional_pump_out <= DRIVE_RESET;
            o_integral_pump_out     <= DRIVE_RESET;
            o_speedup               <= 1'b0;
            o_comp_window           <= 1'b0;
        end
        else
        begin
            o_proportional_pump_out <= next_prop;
            o_integral_pump_out     <= next_int;
            o_speedup               <= speedup;
            o_comp_window           <= comp_active;
        end
    end

    // ------------------------------------------------------------------
    // lock detect
    // ------------------------------------------------------------------
    logic main_locked;
    logic aux_locked;

    cpld_lock_mon u_main_lock
    (
        .i_sys_clk  (i_sys_clk),
        .i_reset    (i_reset),
        .i_ref_tick (ref_tick),
        .i_enable   (i_main_enable_bit),
        .i_up       (i_main_up),
        .i_down     (i_main_down),
        .o_locked   (main_locked)
    );

    cpld_lock_mon u_aux_lock
    (
        .i_sys_clk  (i_sys_clk),
        .i_reset    (i_reset),
        .i_ref_tick (ref_tick),
        .i_enable   (i_aux_enable_bit),
        .i_up       (i_aux_up),
        .i_down     (i_aux_down),
        .o_locked   (aux_locked)
    );

    // registered so the pin never shows a half-updated pair
    always_ff @(posedge i_sys_clk)
    begin
        if (i_reset)
            o_lock <= 1'b0;
        else
            o_lock <= main_locked & aux_locked;
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    sequence s_window_open;
        ref_tick && i_ref_pulse_due && comp_state == CMP_IDLE;
    endsequence

    sequence s_window_last;
        ref_tick && !i_ref_pulse_due && comp_state == CMP_AFTER;
    endsequence

    a_window_opens: assert property (@(posedge i_sys_clk)
        disable iff (i_reset)
        s_window_open |=> comp_state == CMP_BEFORE ##1 o_comp_window)
        else $error("compensation window did not open");

    a_window_closes: assert property (@(posedge i_sys_clk)
        disable iff (i_reset)
        s_window_last |=> ##1 !o_comp_window &&
            o_proportional_pump_out.comp_mag == MAG_ZERO)
        else $error("compensation window did not close");

    a_speedup_strobe: assert property (@(posedge i_sys_clk)
        disable iff (i_reset)
        (i_aword_load ##1 i_strobe) |=> o_speedup)
        else $error("speed-up missing while strobe high");

    a_normal_no_strobe: assert property (@(posedge i_sys_clk)
        disable iff (i_reset) !i_strobe |=> !o_speedup)
        else $error("speed-up with strobe low");

    a_integral_zero: assert property (@(posedge i_sys_clk)
        disable iff (i_reset)
        !o_speedup |-> o_integral_pump_out.pump_mag == MAG_ZERO &&
            o_integral_pump_out.comp_mag == MAG_ZERO)
        else $error("integral output active in normal mode");

    a_normal_gain: assert property (@(posedge i_sys_clk)
        disable iff (i_reset)
        !speedup && !i_aword_load |=>
            o_proportional_pump_out.pump_mag[GAIN_W-1:0] ==
            codes.pump_gain_code)
        else $error("normal pump magnitude differs from gain code");

    a_normal_comp: assert property (@(posedge i_sys_clk)
        disable iff (i_reset)
        !speedup && comp_active |=>
            o_proportional_pump_out.comp_mag ==
            {{(MAG_W-FRAC_W){1'b0}}, $past(frac_acc)})
        else $error("normal compensation differs from residue");

    a_speedup_prop: assert property (@(posedge i_sys_clk)
        disable iff (i_reset)
        speedup && !i_aword_load |=> o_proportional_pump_out.pump_mag ==
            scale(pump_n, factor + MAG_ONE))
        else $error("speed-up proportional pump magnitude wrong");

    a_speedup_int: assert property (@(posedge i_sys_clk)
        disable iff (i_reset)
        speedup && !i_aword_load |=> o_integral_pump_out.pump_mag ==
            scale(scale(pump_n, factor), ratio))
        else $error("speed-up integral pump magnitude wrong");

    a_lock_both: assert property (@(posedge i_sys_clk)
        disable iff (i_reset)
        o_lock |-> $past(main_locked) && $past(aux_locked))
        else $error("lock high without both detectors locked");

    a_lock_disabled: assert property (@(posedge i_sys_clk)
        disable iff (i_reset)
        (!i_main_enable_bit && !i_aux_enable_bit)[*2] |=> o_lock)
        else $error("lock low with both counters disabled");

    // the step is widened before the compare: a cut modulus of 8 reads 0
    a_frac_modulo: assert property (@(posedge i_sys_clk)
        disable iff (i_reset)
        i_main_div_pulse && {1'b0, i_frac_step} < frac_mod |=>
            {1'b0, frac_acc} < $past(frac_mod))
        else $error("fraction accumulator left its modulus");

endmodule // cpld_top

/* tb/cpld_ref_model.sv */
// reference input source that feeds the block's reference pin
`timescale 1ns/1ps

module cpld_ref_model
#(
    parameter int HALF = 4  // sys clocks per reference half period
)
(
    input  wire logic i_sys_clk,
    output logic      o_reference_input = 1'b0
);
    // ------------------------------------------------------------------
    // free running reference oscillator
    // ------------------------------------------------------------------
    int cnt = 0;

    // the reference runs free; it is a crystal, not a framed link clock
    always @(posedge i_sys_clk)
    begin
        if (cnt == HALF - 1)
        begin
            cnt <= 0;
            o_reference_input <= ~o_reference_input;
        end
        else
            cnt <= cnt + 1;
    end
endmodule // cpld_ref_model

/* tb/cpld_top_bench.sv */
// self-checking bench for the charge pump control and lock detect
`timescale 1ns/1ps

module cpld_top_bench
    import cpld_pkg::*;
;
    // ------------------------------------------------------------------
    // stimulus and observation
    // ------------------------------------------------------------------
    localparam int HALF  = 4;           // reference half period in clocks
    localparam int LIMIT = 20000;       // far above the whole sequence
    logic        i_sys_clk = 1'b0;
    logic        i_reset = 1'b1;
    logic        ref_in;
    logic        due = 1'b0, div_p = 1'b0, fsel = 1'b1;
    logic [2:0]  step = 3'h0;
    logic        en_m = 1'b0, en_a = 1'b0, ld = 1'b0, stb = 1'b0;
    logic        m_up = 1'b0, m_dn = 1'b0, a_up = 1'b0, a_dn = 1'b0;
    cpld_aword_t aw = AWORD_RESET;
    cpld_drive_t pp, ip;
    logic        spd, win, ovf, lock;
    logic [2:0]  res;
    logic [15:0] f;
    int          error_cnt = 0, samples_checked = 0, cycles = 0, k;

    always #2.5 i_sys_clk = ~i_sys_clk;

    cpld_ref_model #(.HALF(HALF)) i_ref (.i_sys_clk(i_sys_clk),
        .o_reference_input(ref_in));

    cpld_top i_dut (.i_sys_clk(i_sys_clk), .i_reset(i_reset),
        .i_reference_input(ref_in), .i_ref_pulse_due(due),
        .i_main_div_pulse(div_p), .i_frac_step(step),
        .i_fraction_modulus_select(fsel), .i_main_enable_bit(en_m),
        .i_aux_enable_bit(en_a), .i_aword_load(ld), .i_aword(aw),
        .i_strobe(stb), .i_main_up(m_up), .i_main_down(m_dn),
        .i_aux_up(a_up), .i_aux_down(a_dn), .o_proportional_pump_out(pp),
        .o_integral_pump_out(ip), .o_speedup(spd), .o_comp_window(win),
        .o_fraction_residue(res), .o_frac_overflow(ovf), .o_lock(lock));

    // ------------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------------
    // wide enough for a whole drive struct, direction bits included
    task check(input string name, input logic [63:0] seen,
               input logic [63:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("[FAIL] %s expected %0h seen %0h", name, exp, seen);
        end
    endtask

    task finish_test;
        $display("checks %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // wait n edges, then let their updates land before sampling
    task tick(input int n);
        repeat (n) @(posedge i_sys_clk);
        #1;
    endtask

    // one main divider completion with its fraction step
    task frac(input logic [2:0] s, input logic [2:0] r, input logic o);
        @(posedge i_sys_clk);
        div_p <= 1'b1;
        step  <= s;
        @(posedge i_sys_clk);
        div_p <= 1'b0;
        #1;
        check("residue", res, r);
        check("overflow", ovf, o);
    endtask

    // the host loads the A word with the strobe at level s
    task load(input logic [7:0] g, input logic [1:0] c, input logic [3:0] r,
              input logic s);
        @(posedge i_sys_clk);
        ld  <= 1'b1;
        aw  <= '{pump_gain_code: g, speedup_shift_code: c,
                 integral_ratio_code: r};
        stb <= s;
        @(posedge i_sys_clk);
        ld  <= 1'b0;
        tick(3);
    endtask

    // hang guard
    always @(posedge i_sys_clk)
    begin
        cycles++;
        if (cycles == LIMIT)
        begin
            error_cnt++;
            finish_test();
        end
    end

    // ------------------------------------------------------------------
    // test sequence
    // ------------------------------------------------------------------
    initial
    begin
        tick(3);
        check("lock in reset", lock, 1'b0);
        check("prop in reset", pp, DRIVE_RESET);
        i_reset <= 1'b0;
        tick(4);
        // both counters disabled, so both detectors count as locked
        check("lock disabled", lock, 1'b1);
        // modulus 8 then modulus 5, wrap points included
        frac(3'h3, 3'h3, 1'b0);
        frac(3'h3, 3'h6, 1'b0);
        frac(3'h3, 3'h1, 1'b1);
        frac(3'h7, 3'h0, 1'b1);
        fsel <= 1'b0;
        frac(3'h4, 3'h4, 1'b0);
        frac(3'h2, 3'h1, 1'b1);
        frac(3'h2, 3'h3, 1'b0);
        // normal mode after a load with the strobe low
        load(8'h1d, 2'h1, 4'h3, 1'b0);
        check("normal spd", spd, 1'b0);
        check("normal pump", pp.pump_mag, 16'h001d);
        check("comp off", pp.comp_mag, 16'h0000);
        check("normal int", ip, DRIVE_RESET);
        // compensation window around the divider pulse
        @(posedge ref_in);
        @(posedge i_sys_clk);
        due <= 1'b1;
        @(posedge ref_in);
        repeat (2) @(posedge i_sys_clk);
        due <= 1'b0;
        // step off the edge so the window is counted from its first cycle
        #1;
        for (k = 0; k < 40 && win !== 1'b1; k++)
            tick(1);
        check("comp mag", pp.comp_mag, 16'h0003);
        for (k = 0; k < 60 && win === 1'b1; k++)
            tick(1);
        check("window len", k, 6 * HALF);
        check("comp after", pp.comp_mag, 16'h0000);
        // speed-up for every shift code while the strobe stays high
        for (int s = 0; s < 4; s++)
        begin
            load(8'h1d, s[1:0], 4'h3, 1'b1);
            f = 16'h0001 << (s + 1);
            check("spd on", spd, 1'b1);
            check("spd pump", pp.pump_mag, 16'h1d * (f + 1));
            check("int pump", ip.pump_mag, 16'h1d * f * 3);
        end
        stb <= 1'b0;
        tick(3);
        check("spd off", spd, 1'b0);
        check("int off", ip.pump_mag, 16'h0000);
        // strobe high without a fresh load stays in normal mode
        stb <= 1'b1;
        tick(3);
        check("no load spd", spd, 1'b0);
        stb <= 1'b0;
        // main detector: long error loses lock, short error regains it
        en_m <= 1'b1;
        m_up <= 1'b1;
        tick(8 * HALF);
        check("up copy", pp.up, 1'b1);
        check("main slip", lock, 1'b0);
        m_up <= 1'b0;
        tick(2);
        m_up <= 1'b1;
        tick(1);
        m_up <= 1'b0;
        tick(4);
        check("main relock", lock, 1'b1);
        // aux detector slips while main is locked
        en_a <= 1'b1;
        a_dn <= 1'b1;
        tick(8 * HALF);
        check("aux slip", lock, 1'b0);
        en_a <= 1'b0;
        tick(4);
        check("aux disabled", lock, 1'b1);
        a_dn <= 1'b0;
        finish_test();
    end
endmodule // cpld_top_bench
